// [hw/atd_defines.svh]
// How it works
// - Opcode 0001010010 copies all four bits of register X into the accumulator, X unchanged.
// - Opcode 0000011111 loads the accumulator with the value held in register Y.
// - Opcode 0001010011 puts Z into accumulator bits 1..0 and zero into bits 3..2.
// - Opcode 0000001110 writes the accumulator into register B, accumulator unchanged.
`ifndef ATD_DEFINES_SVH
`define ATD_DEFINES_SVH

`define ATD_OPC_W 10
`define ATD_DATA_W 4
`define ATD_Z_W 2

`define ATD_OPC_X_TO_ACC 10'h052
`define ATD_OPC_Y_TO_ACC 10'h01f
`define ATD_OPC_Z_TO_ACC 10'h053
`define ATD_OPC_ACC_TO_B 10'h00e

`define ATD_INSTR_WORDS 2'h1
`define ATD_INSTR_CYCLES 2'h1

`define ATD_RST_DATA 4'h0
`define ATD_ACC_HIGH_ZERO 2'h0

`endif

// [hw/atd_pkg.sv]
`include "atd_defines.svh"

package atd_pkg;

  // Decoded transfer kind; the usual decode path steps through Gray neighbours.
  typedef enum logic [2:0]
  {
    ATD_OP_NONE = 3'h0,
    ATD_OP_X_TO_ACC = 3'h1,
    ATD_OP_Y_TO_ACC = 3'h3,
    ATD_OP_Z_TO_ACC = 3'h2,
    ATD_OP_ACC_TO_B = 3'h6
  } atd_op_e;

  typedef struct packed
  {
    logic [`ATD_DATA_W-1:0] x;
    logic [`ATD_DATA_W-1:0] y;
    logic [`ATD_Z_W-1:0] z;
    logic [`ATD_DATA_W-1:0] acc;
  } atd_regs_s;

  typedef struct packed
  {
    logic acc_we;
    logic [`ATD_DATA_W-1:0] acc_data;
    logic b_we;
    logic [`ATD_DATA_W-1:0] b_data;
    logic carry_we;
    logic skip;
  } atd_wr_s;

  typedef struct packed
  {
    atd_op_e op;
    atd_wr_s wr;
    logic done;
    logic [1:0] pc_inc;
  } atd_state_s;

endpackage

// [hw/atd_core.sv]
`timescale 1ns/10ps
`include "atd_defines.svh"

module atd_core
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [`ATD_OPC_W-1:0] i_opcode,
  input wire atd_pkg::atd_regs_s i_regs,
  output atd_pkg::atd_wr_s o_wr,
  output atd_pkg::atd_op_e o_op,
  output logic o_done,
  output logic [1:0] o_pc_inc
);
  import atd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////

  // Shared by the next-state logic and the checks so both agree on the opcode map.
  function automatic atd_op_e atd_decode(input logic [`ATD_OPC_W-1:0] opc);
    atd_op_e op;
    op = ATD_OP_NONE;
    unique case (opc)
      `ATD_OPC_X_TO_ACC: op = ATD_OP_X_TO_ACC;
      `ATD_OPC_Y_TO_ACC: op = ATD_OP_Y_TO_ACC;
      `ATD_OPC_Z_TO_ACC: op = ATD_OP_Z_TO_ACC;
      `ATD_OPC_ACC_TO_B: op = ATD_OP_ACC_TO_B;
      default: op = ATD_OP_NONE;
    endcase
    return op;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  atd_state_s state_q;
  atd_state_s state_d;
  atd_op_e op_now;
  // One decoded-transfer flag, shared by the completion logic and the checks.
  logic issue_now;

  assign op_now = i_valid ? atd_decode(i_opcode) : ATD_OP_NONE;
  assign issue_now = (op_now != ATD_OP_NONE);

  always_comb
  begin
    state_d = '0;
    state_d.op = op_now;
    state_d.wr.acc_data = `ATD_RST_DATA;
    state_d.wr.b_data = `ATD_RST_DATA;
    // Transfers never touch the carry flag and never request a skip.
    state_d.wr.carry_we = 1'b0;
    state_d.wr.skip = 1'b0;
    unique case (op_now)
      ATD_OP_X_TO_ACC:
      begin
        state_d.wr.acc_we = 1'b1;
        state_d.wr.acc_data = i_regs.x;
      end
      ATD_OP_Y_TO_ACC:
      begin
        state_d.wr.acc_we = 1'b1;
        state_d.wr.acc_data = i_regs.y;
      end
      ATD_OP_Z_TO_ACC:
      begin
        state_d.wr.acc_we = 1'b1;
        state_d.wr.acc_data = {`ATD_ACC_HIGH_ZERO, i_regs.z};
      end
      ATD_OP_ACC_TO_B:
      begin
        // The accumulator write enable stays low so A keeps its value.
        state_d.wr.b_we = 1'b1;
        state_d.wr.b_data = i_regs.acc;
      end
      ATD_OP_NONE:
      begin
        state_d.op = ATD_OP_NONE;
      end
    endcase
    // Completion is signalled in the very next cycle, one word consumed.
    if (issue_now)
    begin
      state_d.done = 1'b1;
      state_d.pc_inc = `ATD_INSTR_WORDS;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_wr = state_q.wr;
  assign o_op = state_q.op;
  assign o_done = state_q.done;
  assign o_pc_inc = state_q.pc_inc;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_issue(logic [`ATD_OPC_W-1:0] opc);
    i_valid && (i_opcode == opc);
  endsequence

  sequence seq_acc_gets(logic [`ATD_DATA_W-1:0] val);
    o_wr.acc_we && !o_wr.b_we && (o_wr.acc_data == val);
  endsequence

  sequence seq_one_word;
    o_done && (o_pc_inc == `ATD_INSTR_WORDS);
  endsequence

  // A quiet cycle: nothing completes, nothing is written, the program counter stands.
  sequence seq_quiet;
    !o_done && !o_wr.acc_we && !o_wr.b_we && (o_pc_inc == 2'h0);
  endsequence

  AST_X_TO_ACC: assert property (seq_issue(`ATD_OPC_X_TO_ACC) |=>
    seq_acc_gets($past(i_regs.x)))
    else $error("X transfer did not load the accumulator with X.");

  AST_Y_TO_ACC: assert property (seq_issue(`ATD_OPC_Y_TO_ACC) |=>
    seq_acc_gets($past(i_regs.y)))
    else $error("Y transfer did not load the accumulator with Y.");

  AST_Z_TO_ACC: assert property (seq_issue(`ATD_OPC_Z_TO_ACC) |=>
    seq_acc_gets({`ATD_ACC_HIGH_ZERO, $past(i_regs.z)}))
    else $error("Z transfer did not zero-extend Z into the accumulator.");

  AST_Z_HIGH_ZERO: assert property ((o_op == ATD_OP_Z_TO_ACC) |->
    (o_wr.acc_data[3:2] == `ATD_ACC_HIGH_ZERO))
    else $error("Z transfer left high accumulator bits nonzero.");

  AST_ACC_TO_B: assert property (seq_issue(`ATD_OPC_ACC_TO_B) |=>
    (o_wr.b_we && !o_wr.acc_we && (o_wr.b_data == $past(i_regs.acc))))
    else $error("B transfer did not copy the accumulator or disturbed it.");

  AST_ONE_CYCLE: assert property ((i_valid && (atd_decode(i_opcode) != ATD_OP_NONE)) |=>
    (o_done && (o_pc_inc == `ATD_INSTR_WORDS)) ##1 (!o_done || $past(issue_now)))
    else $error("Transfer did not complete in exactly one cycle.");

  AST_NO_CARRY_NO_SKIP: assert property (o_done |->
    (!o_wr.carry_we && !o_wr.skip))
    else $error("Transfer touched carry or requested a skip.");

  AST_IDLE_QUIET: assert property ((!i_valid || (atd_decode(i_opcode) == ATD_OP_NONE))
    |=> (!o_done && !o_wr.acc_we && !o_wr.b_we && (o_pc_inc == 2'h0)))
    else $error("Outputs active without a decoded transfer.");

  // Each opcode must also report its own kind, so a mixed-up write path cannot hide.
  AST_OP_X: assert property (seq_issue(`ATD_OPC_X_TO_ACC) |=> (o_op == ATD_OP_X_TO_ACC))
    else $error("X transfer reported the wrong kind.");

  AST_OP_Y: assert property (seq_issue(`ATD_OPC_Y_TO_ACC) |=> (o_op == ATD_OP_Y_TO_ACC))
    else $error("Y transfer reported the wrong kind.");

  AST_OP_Z: assert property (seq_issue(`ATD_OPC_Z_TO_ACC) |=> (o_op == ATD_OP_Z_TO_ACC))
    else $error("Z transfer reported the wrong kind.");

  AST_OP_B: assert property (seq_issue(`ATD_OPC_ACC_TO_B) |=> (o_op == ATD_OP_ACC_TO_B))
    else $error("B transfer reported the wrong kind.");

  AST_B_ONLY_ON_STORE: assert property (o_wr.b_we |-> (o_op == ATD_OP_ACC_TO_B))
    else $error("B written by a transfer that is not a store.");

  AST_ACC_ONLY_ON_LOAD: assert property (o_wr.acc_we |->
    ((o_op != ATD_OP_NONE) && (o_op != ATD_OP_ACC_TO_B)))
    else $error("Accumulator written by a transfer that is not a load.");

  AST_STORE_NO_ACC_DATA: assert property ((o_op == ATD_OP_ACC_TO_B) |->
    (o_wr.acc_data == `ATD_RST_DATA))
    else $error("Store drove accumulator data.");

  AST_LOAD_NO_B_DATA: assert property (o_wr.acc_we |-> (o_wr.b_data == `ATD_RST_DATA))
    else $error("Load drove B data.");

  // The upper accumulator bits have no source on a Z transfer, so each is checked alone.
  for (genvar g = `ATD_Z_W; g < `ATD_DATA_W; g++)
  begin : g_z_high
    AST_Z_UPPER_BIT: assert property ((o_op == ATD_OP_Z_TO_ACC) |-> !o_wr.acc_data[g])
      else $error("Z transfer set an upper accumulator bit.");
  end

  AST_ONE_WRITE: assert property (o_done |-> (o_wr.acc_we != o_wr.b_we))
    else $error("A transfer must write exactly one register.");

  AST_DONE_HAS_OP: assert property (o_done |-> (o_op != ATD_OP_NONE))
    else $error("Completion reported without a transfer kind.");

  AST_OP_ONLY_WITH_DONE: assert property ((o_op != ATD_OP_NONE) |-> seq_one_word)
    else $error("Transfer kind reported without completion.");

  AST_PC_ONLY_ON_DONE: assert property ((o_pc_inc != 2'h0) |-> seq_one_word)
    else $error("Program counter advanced without a completed transfer.");

  // Idle cycles must be silent; a stray write enable would corrupt the register file.
  AST_INVALID_QUIET: assert property (!i_valid |=> seq_quiet)
    else $error("Outputs active after a cycle with no instruction.");

  AST_REFUSED_OP: assert property ((i_valid && (atd_decode(i_opcode) == ATD_OP_NONE))
    |=> ((o_op == ATD_OP_NONE) && !o_done))
    else $error("Unknown opcode was reported as a transfer.");

  AST_IDLE_DATA_ZERO: assert property (!o_done |->
    ((o_wr.acc_data == `ATD_RST_DATA) && (o_wr.b_data == `ATD_RST_DATA)))
    else $error("Write data not cleared in a cycle without a transfer.");

  // No bubble is allowed between transfers; the core issues one word per cycle.
  AST_BACK_TO_BACK: assert property ((issue_now ##1 issue_now) |->
    (seq_one_word ##1 seq_one_word))
    else $error("Back-to-back transfers did not complete one per cycle.");

  // The carry flag belongs to the arithmetic path, so no cycle may even ask to write it.
  AST_NEVER_CARRY: assert property (!o_wr.carry_we && !o_wr.skip)
    else $error("Carry write or skip raised.");

endmodule

// [verif/atd_rf_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module atd_rf_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire atd_pkg::atd_wr_s i_wr,
  input wire logic i_load,
  input wire atd_pkg::atd_regs_s i_init,
  output atd_pkg::atd_regs_s o_regs,
  output logic [3:0] o_b
);
  import atd_pkg::*;
  // Writes land one edge after the core reports them, as a real register file would.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_regs <= '0;
      o_b <= '0;
    end
    else if (i_load)
      o_regs <= i_init;
    else
    begin
      if (i_wr.acc_we)
        o_regs.acc <= i_wr.acc_data;
      if (i_wr.b_we)
        o_b <= i_wr.b_data;
    end
  end
endmodule

// [verif/accumulator_transfer_decode_test.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module accumulator_transfer_decode_test;
  import atd_pkg::*;
  logic i_clk_sys = 0;
  logic i_rst_n = 0;
  logic i_valid = 0;
  logic ld = 0;
  logic [9:0] opc = '0;
  atd_regs_s regs;
  atd_regs_s init = '0;
  atd_wr_s wr;
  atd_op_e op;
  logic done;
  logic [1:0] pc;
  logic [3:0] b;
  int errors = 0;
  int n_tests = 0;
  atd_core atd_core_i(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_opcode(opc), .i_regs(regs), .o_wr(wr), .o_op(op), .o_done(done), .o_pc_inc(pc));
  atd_rf_model atd_rf_model_i(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wr(wr),
    .i_load(ld), .i_init(init), .o_regs(regs), .o_b(b));
  initial forever #2 i_clk_sys = ~i_clk_sys;
  ////////////////////////////////////////////////////////////////
  task chk(input logic [17:0] exp);
    n_tests++;
    if ({wr, op, done, pc} !== exp)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, {wr, op, done, pc}, exp);
    end
  endtask
  task chk_rf(input logic [11:0] exp);
    n_tests++;
    if ({b, regs.x, regs.acc} !== exp)
    begin
      errors++;
      $display("BAD %0t regs %h exp %h", $time, {b, regs.x, regs.acc}, exp);
    end
  endtask
  task t_reset;
    repeat (5) @(posedge i_clk_sys);
    #1;
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
    i_rst_n = 1;
  endtask
  // Carry write and skip are expected low always; done and one word go with any op.
  function automatic logic [17:0] ex(logic aw, logic [3:0] ad, logic bw, logic [3:0] bd,
    logic [2:0] o);
    return {aw, ad, bw, bd, 2'h0, o, o != 3'h0, (o != 3'h0) ? 2'h1 : 2'h0};
  endfunction
  task step(input logic v, input logic [9:0] o);
    @(posedge i_clk_sys);
    #1;
    i_valid = v;
    opc = o;
  endtask
  // Back to back; the copy to B sees the Y value, since the Z write lands on that same edge.
  task t_all_moves;
    init = {4'ha, 4'h5, 2'h2, 4'h9};
    ld = 1;
    step(0, 10'h000);
    ld = 0;
    step(1, 10'h052);
    step(1, 10'h01f);
    chk(ex(1, 4'ha, 0, 4'h0, 3'h1));
    step(1, 10'h053);
    chk(ex(1, 4'h5, 0, 4'h0, 3'h3));
    step(1, 10'h00e);
    chk(ex(1, 4'h2, 0, 4'h0, 3'h2));
    step(0, 10'h000);
    chk(ex(0, 4'h0, 1, 4'h5, 3'h6));
    step(0, 10'h000);
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
    chk_rf({4'h5, 4'ha, 4'h2});
  endtask
  task t_refused;
    step(1, 10'h3ff);
    step(0, 10'h052);
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
    step(1, 10'h0a6);
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
    step(0, 10'h000);
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
  endtask
  // A reset on the issue edge swallows the transfer; the request after release works.
  task t_reset_mid;
    step(1, 10'h052);
    i_rst_n = 0;
    init = {4'h3, 4'hc, 2'h1, 4'h6};
    step(0, 10'h000);
    i_rst_n = 1;
    ld = 1;
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
    step(1, 10'h053);
    ld = 0;
    chk(ex(0, 4'h0, 0, 4'h0, 3'h0));
    step(1, 10'h01f);
    chk(ex(1, 4'h1, 0, 4'h0, 3'h2));
    step(0, 10'h000);
    chk(ex(1, 4'hc, 0, 4'h0, 3'h3));
    step(0, 10'h000);
    chk_rf({4'h0, 4'h3, 4'hc});
  endtask
  task results;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_all_moves();
    t_refused();
    t_reset_mid();
    results();
  end
endmodule
